// ---- logic/srr_speed_ramp.sv ----
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
module srr_speed_ramp import srr_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int MINUTE_COUNT = MINUTE_TICKS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Contact inputs
  input wire logic RUN_FORWARD,
  input wire logic RUN_REVERSE,
  input wire logic REMOTE_UP,
  input wire logic REMOTE_DOWN,
  input wire logic REMOTE_CLEAR,
  input wire logic SECOND_FUNCTION_SELECT,
  // Analog main speed, 0.01 Hz
  input wire logic [15:0] MAIN_SPEED,
  // Drive reference
  output logic [15:0] OUT_FREQ,
  output logic OUT_REVERSE,
  output logic RAMP_BUSY,
  output logic [15:0] SET_FREQ,
  // Multi-speed selects in mode zero
  output logic [2:0] MULTI_SPEED_SEL,
  // Nonvolatile store request
  output logic NV_WR_STB,
  output logic [16:0] NV_WR_DATA
);
  // Software registers
  logic [3:0] ctrl_q; // Shape, PM motor, sensorless
  logic [3:0] mode_q; // Remote mode select
  logic [31:0] time1_q, time2_q; // Accel low, decel high
  logic [31:0] freqs_q; // Base low, rated high
  logic [31:0] limits_q; // Ramp reference low, max high
  logic [OW-1:0] stored_q; // Stored biased offset
  // Bus decode
  logic [31:0] rdata, wnew, prdata_q;
  logic hit, wr_en, restore;
  // Time base
  logic [31:0] tick_cnt_q, min_cnt_q;
  logic tick, minute;
  // Remote logic
  logic remote_on, below_ok, store_en, stop_clr;
  logic up_r, down_r, run, run_q, run_fall, armed_q, save;
  logic [OW-1:0] off_cur, off_tgt, off_hi, off_lo, off_load_val;
  logic off_load, dir_q, run_ok;
  logic [17:0] set_sum;
  logic [15:0] set_q, out_tgt, infl;
  logic [1:0] shape;
  logic [15:0] acc_t, dec_t;
  logic out_busy, nv_stb_q;

  // Access handshake
  assign wr_en = PSEL & PENABLE & PWRITE & hit;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit;
  assign PRDATA = prdata_q;

  // Read view of the addressed register
  always_comb begin
    rdata = 32'h0;
    hit = 1'b1;
    case (PADDR)
      OFF_CTRL: rdata = {28'h0, ctrl_q};
      OFF_MODE: rdata = {28'h0, mode_q};
      OFF_TIME1: rdata = time1_q;
      OFF_TIME2: rdata = time2_q;
      OFF_FREQS: rdata = freqs_q;
      OFF_LIMITS: rdata = limits_q;
      OFF_STORED: rdata = {15'h0, stored_q};
      OFF_STATUS: begin
        rdata[15:0] = OUT_FREQ;
        rdata[ST_BUSY_BIT] = out_busy;
        rdata[ST_REV_BIT] = dir_q;
        rdata[ST_RUN_BIT] = run_ok;
      end
      OFF_SETF: rdata = {16'h0, set_q};
      default: hit = 1'b0; // Unmapped or unaligned
    endcase
  end

  // Byte lane merge of write data
  always_comb begin
    wnew = rdata;
    for (int i = 0; i < 4; i++) begin
      if (PSTRB[i]) begin
        wnew[8*i +: 8] = PWDATA[8*i +: 8];
      end
    end
  end

  assign restore = wr_en && PADDR == OFF_CTRL && wnew[CTRL_RESTORE_BIT];

  // Read data captured in the setup cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_q <= 32'h0;
    end else if (PSEL && !PENABLE) begin
      prdata_q <= rdata;
    end
  end

  // Configuration registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_RST;
      mode_q <= MODE_RST;
      time1_q <= TIME_RST;
      time2_q <= TIME_RST;
      freqs_q <= FREQS_RST;
      limits_q <= LIMITS_RST;
    end else if (wr_en) begin
      case (PADDR)
        OFF_CTRL: ctrl_q <= wnew[3:0];
        OFF_MODE: mode_q <= wnew[3:0];
        OFF_TIME1: time1_q <= wnew;
        OFF_TIME2: time2_q <= wnew;
        OFF_FREQS: freqs_q <= wnew;
        OFF_LIMITS: limits_q <= wnew;
        default: ctrl_q <= ctrl_q; // Read-only or stored
      endcase
    end
  end

  // Ramp tick generator
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_q <= 32'h0;
    end else if (tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end
  assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);

  // Remote mode decode
  assign remote_on = mode_q != REM_OFF;
  assign below_ok = mode_q >= REM_LOW_MIN;
  assign store_en = mode_q == REM_STORE || mode_q == REM_STORE_LOW;
  assign stop_clr = mode_q == REM_CLEAR || mode_q == REM_CLEAR_LOW;
  assign up_r = REMOTE_UP & remote_on;
  assign down_r = REMOTE_DOWN & remote_on;

  // Run command, both inputs together mean stop
  assign run = RUN_FORWARD ^ RUN_REVERSE;
  assign run_fall = run_q & ~run;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run;
    end
  end

  // Multi-speed selects pass through in mode zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MULTI_SPEED_SEL <= 3'h0;
    end else if (remote_on) begin
      MULTI_SPEED_SEL <= 3'h0;
    end else begin
      MULTI_SPEED_SEL <= {REMOTE_CLEAR, REMOTE_DOWN, REMOTE_UP};
    end
  end

  // Offset limits, biased so zero offset is OFF_BIAS
  assign off_hi = OFF_BIAS + OW'(limits_q[31:16]);
  assign off_lo = below_ok ? OFF_BIAS - OW'(MAIN_SPEED) : OFF_BIAS;

  // Offset target from up and down
  always_comb begin
    off_tgt = off_cur;
    if (up_r && !down_r) begin
      off_tgt = off_hi;
    end else if (down_r && !up_r) begin
      off_tgt = off_lo;
    end
    if (off_tgt > off_hi) begin
      off_tgt = off_hi;
    end
    if (off_tgt < off_lo && (up_r ^ down_r)) begin
      off_tgt = off_lo;
    end
  end

  // Offset clear and restore
  always_comb begin
    off_load = 1'b0;
    off_load_val = OFF_BIAS;
    if (REMOTE_CLEAR && remote_on) begin
      off_load = 1'b1;
    end else if (run_fall && stop_clr) begin
      off_load = 1'b1;
    end else if (restore) begin
      off_load = 1'b1;
      off_load_val = stored_q;
    end
  end

  // Set frequency moves at the second times
  srr_ramp_eng #(
    .W(OW)
  ) u_offset (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(tick),
    .shape(SHAPE_LIN),
    .lin_force(1'b0),
    .sensorless(1'b0),
    .t_acc(time2_q[15:0]),
    .t_dec(time2_q[31:16]),
    .ref_freq(limits_q[15:0]),
    .infl_freq(16'h0),
    .target(off_tgt),
    .load(off_load),
    .load_val(off_load_val),
    .freq(off_cur),
    .busy()
  );

  // Main speed plus offset, clamped
  assign set_sum = 18'(MAIN_SPEED) + 18'(off_cur) - 18'(OFF_BIAS);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      set_q <= 16'h0;
    end else if (!remote_on) begin
      set_q <= MAIN_SPEED;
    end else if (set_sum[17]) begin
      set_q <= 16'h0;
    end else if (set_sum[16]) begin
      set_q <= 16'hFFFF;
    end else begin
      set_q <= set_sum[15:0];
    end
  end
  assign SET_FREQ = set_q;

  // Direction changes only at standstill
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dir_q <= 1'b0;
    end else if (run && OUT_FREQ == 16'h0) begin
      dir_q <= RUN_REVERSE;
    end
  end
  assign run_ok = run && dir_q == RUN_REVERSE;
  assign OUT_REVERSE = dir_q;
  assign out_tgt = run_ok ? set_q : 16'h0;

  // Output ramp configuration
  assign shape = ctrl_q[1:0];
  assign infl = ctrl_q[CTRL_PM_BIT] ? freqs_q[31:16] : freqs_q[15:0];
  assign acc_t = SECOND_FUNCTION_SELECT ? time2_q[15:0] : time1_q[15:0];
  assign dec_t = SECOND_FUNCTION_SELECT ? time2_q[31:16] : time1_q[31:16];

  // Output frequency follows set frequency
  srr_ramp_eng #(
    .W(FW)
  ) u_output (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(tick),
    .shape(shape),
    .lin_force(SECOND_FUNCTION_SELECT),
    .sensorless(ctrl_q[CTRL_SLV_BIT]),
    .t_acc(acc_t),
    .t_dec(dec_t),
    .ref_freq(limits_q[15:0]),
    .infl_freq(infl),
    .target(out_tgt),
    .load(1'b0),
    .load_val(16'h0),
    .freq(OUT_FREQ),
    .busy(out_busy)
  );
  assign RAMP_BUSY = out_busy;

  // Minute compare armed by up or down activity
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      armed_q <= 1'b0;
    end else if (up_r || down_r) begin
      armed_q <= 1'b1;
    end else if (minute) begin
      armed_q <= 1'b0;
    end
  end

  // Minute counter in ticks
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      min_cnt_q <= 32'h0;
    end else if (!armed_q || minute) begin
      min_cnt_q <= 32'h0;
    end else if (tick) begin
      min_cnt_q <= min_cnt_q + 32'h1;
    end
  end
  assign minute = armed_q && tick && min_cnt_q == 32'(MINUTE_COUNT - 1);

  // Save at run drop, or on a changed value each minute
  assign save = store_en &&
      (run_fall || (minute && off_cur != stored_q));

  // Stored value, hardware save wins over software
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stored_q <= OFF_BIAS;
    end else if (save) begin
      stored_q <= off_cur;
    end else if (wr_en && PADDR == OFF_STORED) begin
      stored_q <= wnew[OW-1:0];
    end
  end

  // Store request strobe with the new value
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      nv_stb_q <= 1'b0;
    end else begin
      nv_stb_q <= save;
    end
  end
  assign NV_WR_STB = nv_stb_q;
  assign NV_WR_DATA = stored_q;
endmodule // srr_speed_ramp

// ---- logic/srr_pkg.sv ----
package srr_pkg;
  // Clock and ramp time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_MS = 1;
  localparam int TICK_NS = TICK_MS * 1000000;
  // Clock cycles per ramp tick
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // One unit of ramp time is 0.1 s
  localparam int TIME_UNIT_MS = 100;
  localparam int TICKS_PER_TU = TIME_UNIT_MS / TICK_MS;
  // Storage compare period
  localparam int MINUTE_MS = 60000;
  localparam int MINUTE_TICKS = MINUTE_MS / TICK_MS;

  // Widths
  localparam int FW = 16;
  localparam int OW = 17;
  localparam int ACC_W = 48;

  // Ramp shape codes
  typedef enum logic [1:0] {
    SHAPE_LIN = 2'h0,
    SHAPE_SA = 2'h1,
    SHAPE_SB = 2'h2,
    SHAPE_RSV = 2'h3
  } srr_shape_t;

  // Remote mode codes
  localparam logic [3:0] REM_OFF = 4'h0;
  localparam logic [3:0] REM_STORE = 4'h1;
  localparam logic [3:0] REM_CLEAR = 4'h3;
  localparam logic [3:0] REM_STORE_LOW = 4'hB;
  localparam logic [3:0] REM_LOW_MIN = 4'hB;
  localparam logic [3:0] REM_CLEAR_LOW = 4'hD;

  // S-curve rate factors
  localparam logic [ACC_W-1:0] SA_NUM_K = 48'h9;
  localparam logic [ACC_W-1:0] SA_COST_K = 48'h8;
  localparam logic [ACC_W-1:0] S_NUM_K = 48'h2;
  localparam logic [ACC_W-1:0] S_SLOW_K = 48'h3;

  // Offset bias: zero offset
  localparam logic [OW-1:0] OFF_BIAS = 17'h10000;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_TIME1 = 8'h08;
  localparam logic [7:0] OFF_TIME2 = 8'h0C;
  localparam logic [7:0] OFF_FREQS = 8'h10;
  localparam logic [7:0] OFF_LIMITS = 8'h14;
  localparam logic [7:0] OFF_STORED = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_SETF = 8'h20;

  // Field positions
  localparam int CTRL_PM_BIT = 2;
  localparam int CTRL_SLV_BIT = 3;
  localparam int CTRL_RESTORE_BIT = 4;
  localparam int ST_BUSY_BIT = 16;
  localparam int ST_REV_BIT = 17;
  localparam int ST_RUN_BIT = 18;

  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [31:0] TIME_RST = 32'h0032_0032;
  localparam logic [31:0] FREQS_RST = 32'h1770_1770;
  localparam logic [31:0] LIMITS_RST = 32'h2EE0_1770;
endpackage

// ---- logic/srr_ramp_eng.sv ----
`timescale 1ns/10ps
module srr_ramp_eng import srr_pkg::*; #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Time base and shape
  input wire logic tick,
  input wire logic [1:0] shape,
  input wire logic lin_force,
  input wire logic sensorless,
  // Ramp times in 0.1 s, frequencies in 0.01 Hz
  input wire logic [15:0] t_acc,
  input wire logic [15:0] t_dec,
  input wire logic [15:0] ref_freq,
  input wire logic [15:0] infl_freq,
  // Target and direct load
  input wire logic [W-1:0] target,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Result
  output logic [W-1:0] freq,
  output logic busy
);
  logic [W-1:0] freq_q, start_q, tgt_q; // Value, ramp start, last target
  logic lin_q; // Linear override of a running ramp
  logic [ACC_W-1:0] acc_q, num, cost, denom;
  logic up;
  logic [15:0] t_act;
  logic [1:0] shape_eff;
  logic [W+1:0] span4, done4, span3;
  logic outer, low_half;

  assign up = target > freq_q;
  assign t_act = up ? t_acc : t_dec;
  assign busy = freq_q != target;
  assign freq = freq_q;
  // Ticks needed for one reference span
  assign denom = ACC_W'(t_act) * ACC_W'(TICKS_PER_TU);

  // Position inside the present ramp span
  always_comb begin
    span4 = (W+2)'(up ? target - start_q : start_q - target) << 2;
    span3 = (W+2)'(up ? target - start_q : start_q - target) * (W+2)'(3);
    done4 = (W+2)'(up ? freq_q - start_q : start_q - freq_q) << 2;
    outer = (done4 < (span4 >> 2) * (W+2)'(1)) || (done4 >= span3);
    low_half = ACC_W'(freq_q) < (ACC_W'(infl_freq) >> 1);
  end

  // Effective shape
  always_comb begin
    shape_eff = shape;
    if (shape == SHAPE_RSV || (shape == SHAPE_SA && infl_freq == '0)) begin
      shape_eff = SHAPE_LIN;
    end
    if (lin_q || (sensorless && t_act == '0)) begin
      shape_eff = SHAPE_LIN;
    end
  end

  // Gain per tick and cost per step
  always_comb begin
    num = ACC_W'(ref_freq);
    cost = denom;
    case (shape_eff)
      SHAPE_SA: begin
        if (ACC_W'(freq_q) >= ACC_W'(infl_freq)) begin
          // Constant power region, time grows with f squared
          num = SA_NUM_K * ACC_W'(infl_freq) * ACC_W'(infl_freq);
          cost = SA_COST_K * denom * ACC_W'(freq_q);
        end else begin
          // Speeding up toward the inflection point
          num = S_NUM_K * ACC_W'(infl_freq);
          cost = low_half ? S_SLOW_K * denom : denom;
        end
      end
      SHAPE_SB: begin
        // Slow at both ends of the span
        num = S_NUM_K * ACC_W'(ref_freq);
        cost = outer ? S_SLOW_K * denom : denom;
      end
      default: begin
        num = ACC_W'(ref_freq);
      end
    endcase
  end

  // Stepping: ticks feed credit, idle cycles spend it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_q <= '0;
      acc_q <= '0;
    end else if (load) begin
      freq_q <= load_val;
      acc_q <= '0;
    end else if (!busy) begin
      acc_q <= '0;
    end else if (t_act == '0) begin
      freq_q <= target;
      acc_q <= '0;
    end else if (tick) begin
      acc_q <= acc_q + num;
    end else if (acc_q >= cost) begin
      // Unit steps stop exactly at target
      acc_q <= acc_q - cost;
      freq_q <= up ? freq_q + W'(1) : freq_q - W'(1);
    end
  end

  // Ramp start capture on each target change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_q <= '0;
      start_q <= '0;
    end else if (target != tgt_q || load) begin
      tgt_q <= target;
      start_q <= load ? load_val : freq_q;
    end
  end

  // Linear override held until the ramp ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lin_q <= 1'b0;
    end else if (target != tgt_q || !busy) begin
      lin_q <= 1'b0;
    end else if (lin_force && shape == SHAPE_SB) begin
      lin_q <= 1'b1;
    end
  end
endmodule // srr_ramp_eng

// ---- tb/srr_contacts.sv ----
`timescale 1ns/10ps
module srr_contacts (
  // Clock
  input wire logic clk,
  // Wanted levels {second, clear, down, up, rev, fwd}
  input wire logic [5:0] want,
  input wire logic [15:0] want_speed,
  // Contact and analog levels seen by the drive
  output logic [5:0] contact = 6'h00,
  output logic [15:0] speed = 16'h0000
);
  // Contacts settle one clock after the request, like a relay
  always @(posedge clk) begin
    contact <= want;
    speed <= want_speed;
  end
endmodule // srr_contacts

// ---- tb/srr_speed_ramp_checker.sv ----
`timescale 1ns/10ps
module srr_speed_ramp_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Watched ports
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PSLVERR,
  input wire logic RUN_FORWARD,
  input wire logic RUN_REVERSE,
  input wire logic REMOTE_UP,
  input wire logic REMOTE_DOWN,
  input wire logic REMOTE_CLEAR,
  input wire logic [15:0] MAIN_SPEED,
  input wire logic [15:0] OUT_FREQ,
  input wire logic OUT_REVERSE,
  input wire logic RAMP_BUSY,
  input wire logic [15:0] SET_FREQ,
  input wire logic [2:0] MULTI_SPEED_SEL,
  input wire logic NV_WR_STB
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Steady forward run toward a fixed set value
  sequence s_fwd;
    RUN_FORWARD && !RUN_REVERSE && !OUT_REVERSE && $stable(SET_FREQ);
  endsequence
  // Both run contacts open
  sequence s_stop;
    !RUN_FORWARD && !RUN_REVERSE;
  endsequence
  // Up and down together, nothing else moving
  sequence s_hold;
    REMOTE_UP && REMOTE_DOWN && !REMOTE_CLEAR && !PSEL &&
    $stable(MAIN_SPEED) && $stable(RUN_FORWARD) && $stable(RUN_REVERSE);
  endsequence
  property p_step;
    OUT_FREQ == $past(OUT_FREQ) || OUT_FREQ == $past(OUT_FREQ) + 16'h0001
    || OUT_FREQ + 16'h0001 == $past(OUT_FREQ);
  endproperty
  a_step: assert property (p_step) else $error("output jumped");
  property p_no_over;
    s_fwd ##1 s_fwd ##0 OUT_FREQ <= SET_FREQ ##1 s_fwd
      |-> OUT_FREQ <= SET_FREQ;
  endproperty
  a_no_over: assert property (p_no_over) else $error("overshoot");
  property p_idle;
    s_fwd [*2] ##0 !RAMP_BUSY |-> OUT_FREQ == SET_FREQ;
  endproperty
  a_idle: assert property (p_idle) else $error("idle off set");
  property p_stop_zero;
    s_stop [*2] ##0 !RAMP_BUSY |-> OUT_FREQ == 16'h0000;
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("stop");
  property p_hold;
    s_hold [*3] |-> $stable(SET_FREQ);
  endproperty
  a_hold: assert property (p_hold) else $error("hold moved");
  property p_clear;
    (REMOTE_CLEAR && $stable(MAIN_SPEED) && MULTI_SPEED_SEL == 3'h0) [*3]
      |-> SET_FREQ == MAIN_SPEED;
  endproperty
  a_clear: assert property (p_clear) else $error("clear");
  property p_msel;
    MULTI_SPEED_SEL != 3'h0 |-> MULTI_SPEED_SEL ==
      {$past(REMOTE_CLEAR), $past(REMOTE_DOWN), $past(REMOTE_UP)};
  endproperty
  a_msel: assert property (p_msel) else $error("select");
  property p_nv_pulse;
    NV_WR_STB |=> !NV_WR_STB;
  endproperty
  a_nv_pulse: assert property (p_nv_pulse) else $error("strobe");
  property p_err;
    PSLVERR |-> PSEL && PENABLE;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
endmodule // srr_speed_ramp_checker

bind srr_speed_ramp srr_speed_ramp_checker i_chk (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PSLVERR(PSLVERR), .RUN_FORWARD(RUN_FORWARD), .RUN_REVERSE(RUN_REVERSE),
  .REMOTE_UP(REMOTE_UP), .REMOTE_DOWN(REMOTE_DOWN),
  .REMOTE_CLEAR(REMOTE_CLEAR), .MAIN_SPEED(MAIN_SPEED),
  .OUT_FREQ(OUT_FREQ), .OUT_REVERSE(OUT_REVERSE), .RAMP_BUSY(RAMP_BUSY),
  .SET_FREQ(SET_FREQ), .MULTI_SPEED_SEL(MULTI_SPEED_SEL),
  .NV_WR_STB(NV_WR_STB)
);

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top import srr_pkg::*; ;
  localparam int TC = 200; // Short ramp tick
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [5:0] want = 6'h00; // {second, clear, down, up, rev, fwd}
  logic [15:0] want_speed = 16'h0000;
  logic [5:0] con;
  logic [15:0] spd, out_freq, set_freq;
  logic [31:0] prdata, rd;
  logic pready, pslverr, out_rev, busy, nv_stb;
  logic [2:0] msel;
  logic [16:0] nv_data;
  logic [31:0] rnd = 32'h30; // Xorshift state
  int err_count = 0;
  int cmp_count = 0;
  // Clock, 20 ns
  always #10 CLK = ~CLK;
  srr_contacts i_srr_contacts (.clk(CLK), .want(want),
    .want_speed(want_speed), .contact(con), .speed(spd));
  srr_speed_ramp #(.TICK_CYCLES(TC), .MINUTE_COUNT(20)) i_srr_speed_ramp (
    .CLK(CLK), .RST_N(RST_N), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(padr), .PWDATA(pwd), .PSTRB(4'hF), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RUN_FORWARD(con[0]),
    .RUN_REVERSE(con[1]), .REMOTE_UP(con[2]), .REMOTE_DOWN(con[3]),
    .REMOTE_CLEAR(con[4]), .SECOND_FUNCTION_SELECT(con[5]),
    .MAIN_SPEED(spd), .OUT_FREQ(out_freq), .OUT_REVERSE(out_rev),
    .RAMP_BUSY(busy), .SET_FREQ(set_freq), .MULTI_SPEED_SEL(msel),
    .NV_WR_STB(nv_stb), .NV_WR_DATA(nv_data));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts and verdict
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Cycles to ramp from rest; A counts time against the inflection
  function automatic int ramp_cyc(input int s, input int f, input int t);
    if (s == 1) begin
      return (4 * t * 100 * f * f / (1200 * 1200) + 5 * t * 100) / 9 * TC;
    end
    return f * t * 100 / 6000 * TC;
  endfunction
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic e);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge CLK);
    pen <= 1'b1;
    do @(posedge CLK); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk(rd, x);
  endtask
  // Start a run and count cycles while the ramp is busy
  task automatic ramp(input logic [5:0] w, output int c);
    int n;
    n = 0;
    c = 0;
    want <= w;
    while (busy !== 1'b1 && n++ < 10) @(posedge CLK);
    while (busy === 1'b1 && c < 60000) begin
      @(posedge CLK);
      c++;
    end
  endtask
  // Drop the run and wait for standstill
  task automatic halt();
    int n;
    n = 0;
    want <= 6'h00;
    while (out_freq !== 16'h0000 && n++ < 30000) @(posedge CLK);
    chk(out_freq, 32'h0);
  endtask
  // Wait for a store strobe
  task automatic wstb(input int lim);
    int n;
    n = 0;
    while (nv_stb !== 1'b1 && n++ < lim) @(posedge CLK);
    chk(nv_stb, 32'h1);
  endtask
  // Hang guard
  initial begin
    #(20 * 95000);
    err_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    logic e;
    int c;
    int off;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    rdc(OFF_CTRL, 32'h0);
    rdc(OFF_TIME1, TIME_RST);
    rdc(OFF_FREQS, FREQS_RST);
    rdc(OFF_LIMITS, LIMITS_RST);
    apb(1'b0, 8'h24, 32'h0, e);
    chk(e, 32'h1);
    wr(OFF_STATUS, 32'hFFFF);
    rdc(OFF_STATUS, 32'h0);
    // Mode zero: contacts pass through as speed selects
    for (int i = 0; i < 20; i++) begin
      rnd = xs(rnd);
      want <= {rnd[3], rnd[2:0], 2'h0};
      want_speed <= {6'h00, rnd[13:4]};
      repeat (3) @(posedge CLK);
      chk(msel, rnd[2:0]);
    end
    want <= 6'h00;
    want_speed <= 16'h04B0;
    wr(OFF_MODE, 32'h2);
    wr(OFF_TIME2, 32'h0003_0003);
    want <= 6'h10;
    repeat (4) @(posedge CLK);
    chk(set_freq, 32'h04B0);
    chk(msel, 32'h0);
    want <= 6'h04;
    repeat (5 * TC) @(posedge CLK);
    want <= 6'h00;
    repeat (TC) @(posedge CLK);
    off = int'(set_freq) - 1200;
    chk(off >= 80 && off <= 120, 32'h1);
    off = int'(set_freq);
    want <= 6'h0C;
    repeat (3 * TC) @(posedge CLK);
    chk(set_freq, off);
    want <= 6'h08;
    repeat (8 * TC) @(posedge CLK);
    chk(set_freq, 32'h04B0);
    wr(OFF_MODE, 32'hC);
    repeat (5 * TC) @(posedge CLK);
    want <= 6'h00;
    repeat (TC) @(posedge CLK);
    off = 1200 - int'(set_freq);
    chk(off >= 80 && off <= 120, 32'h1);
    want <= 6'h10;
    repeat (4) @(posedge CLK);
    want <= 6'h00;
    chk(set_freq, 32'h04B0);
    // Shapes from rest; inflection set equal to the target
    wr(OFF_FREQS, 32'h1770_04B0);
    wr(OFF_TIME1, 32'h0001_0001);
    for (int s = 0; s < 3; s++) begin
      wr(OFF_CTRL, s); // Sensorless stays off with S shapes
      ramp(6'h01, c);
      chk(c > ramp_cyc(s, 1200, 1) - 2 * TC &&
          c < ramp_cyc(s, 1200, 1) + 2 * TC, 32'h1);
      rdc(OFF_STATUS, 32'h0004_04B0);
      halt();
    end
    ramp(6'h02, c);
    rdc(OFF_STATUS, 32'h0006_04B0);
    chk(out_rev, 32'h1);
    halt();
    // Type B with second function: linear at second times, 20 per tick
    want <= 6'h21;
    repeat (5 * TC) @(posedge CLK);
    chk(out_freq > 70 && out_freq < 125, 32'h1);
    halt();
    // PM motor, type A: inflection at rated 6000, 40 per tick low half
    wr(OFF_CTRL, 32'h5);
    want <= 6'h01;
    repeat (5 * TC) @(posedge CLK);
    chk(out_freq > 150 && out_freq < 210, 32'h1);
    halt();
    // Storage at run drop, then at the minute compare armed by up activity
    wr(OFF_MODE, 32'h1);
    want <= 6'h05;
    repeat (5 * TC) @(posedge CLK);
    want <= 6'h01;
    repeat (TC) @(posedge CLK);
    off = int'(set_freq) - 1200;
    want <= 6'h00;
    wstb(20);
    chk(nv_data, 32'h10000 + off);
    rdc(OFF_STORED, 32'h10000 + off);
    want <= 6'h04;
    repeat (2 * TC) @(posedge CLK);
    want <= 6'h00;
    wstb(30 * TC);
    wr(OFF_MODE, 32'h3);
    want <= 6'h05;
    repeat (5 * TC) @(posedge CLK);
    want <= 6'h00;
    repeat (6) @(posedge CLK);
    chk(set_freq, 32'h04B0);
    // Restore an offset of +100 from the stored value
    wr(OFF_STORED, 32'h0001_0064);
    wr(OFF_CTRL, 32'h10);
    repeat (2) @(posedge CLK);
    chk(set_freq, 32'h0514);
    halt();
    tally_and_finish();
  end
endmodule // tb_top
